/* design/i2cr_ctrl.sv */
`timescale 1ns/1ps
module i2cr_ctrl import i2cr_pkg::*; (
	input wire logic clk_i, // system clock
	input wire logic sys_rst_i, // sync reset, active high
	i2cr_if.host bus, // two-wire link
	input wire logic req_valid_i, // command offered
	output logic req_ready_o, // command buffer has room
	input wire logic [1:0] req_kind_i, // command kind
	input wire logic [7:0] req_data_i, // command byte
	output logic rsp_valid_o, // pulse when a byte finished
	output logic [7:0] rsp_data_o, // byte on the line
	output logic rsp_ack_o, // acknowledge seen or driven
	output logic busy_o // work queued or running
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	i2cr_cstate_t state_ff; // sequencer state
	logic [1:0] div_ff; // quarter-bit divider
	logic [1:0] q_ff; // quarter within a bit
	logic [3:0] bit_ff; // bit index, 8 is the ack slot
	logic [7:0] shift_ff; // byte shifter
	logic [1:0] kind_ff; // running command
	logic mack_ff; // ack value to give on read
	logic ackbit_ff; // sampled ack slot level
	logic scl_rel_ff; // clock released
	logic sda_rel_ff; // data released
	logic sda_m_ff, sda_s_ff; // data synchroniser
	logic rsp_valid_ff;
	logic [7:0] rsp_data_ff;
	logic rsp_ack_ff;
	logic tick, f_valid, pop;
	logic [CMD_W-1:0] f_data;

	// ----------------------------------------
	// command buffer
	// ----------------------------------------
	// fills while the line is slow; the user sees back-pressure via ready
	i2cr_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(req_valid_i),
		.in_ready_o(req_ready_o),
		.in_data_i({req_kind_i, req_data_i}),
		.out_valid_o(f_valid),
		.out_ready_i(pop),
		.out_data_o(f_data)
	);
	assign pop = tick & f_valid & (state_ff == CS_IDLE);

	// quarter-bit enable from the system clock, so scl stays at or below 1 MHz
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			div_ff <= 2'h0;
		end else begin
			div_ff <= tick ? 2'h0 : div_ff + 2'h1;
		end
	end
	assign tick = (div_ff == QTR_LAST);

	// data line synchroniser
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sda_m_ff <= 1'b1;
			sda_s_ff <= 1'b1;
		end else begin
			sda_m_ff <= bus.sda;
			sda_s_ff <= sda_m_ff;
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	// sda only moves in quarter 0 while scl is low, except in start/stop
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_ff <= CS_IDLE;
			q_ff <= 2'h0;
			bit_ff <= 4'h0;
			shift_ff <= 8'h00;
			kind_ff <= CMD_START;
			mack_ff <= 1'b1;
			ackbit_ff <= 1'b1;
			scl_rel_ff <= 1'b1;
			sda_rel_ff <= 1'b1;
			rsp_valid_ff <= 1'b0;
			rsp_data_ff <= 8'h00;
			rsp_ack_ff <= 1'b0;
		end else begin
			rsp_valid_ff <= 1'b0;
			if (tick) begin
				q_ff <= q_ff + 2'h1;
				case (state_ff)
					CS_IDLE: begin
						q_ff <= 2'h0;
						bit_ff <= 4'h0;
						if (f_valid) begin
							kind_ff <= f_data[9:8];
							mack_ff <= f_data[0];
							case (f_data[9:8])
								CMD_START: state_ff <= CS_START;
								CMD_STOP: state_ff <= CS_STOP;
								default: state_ff <= CS_BITS;
							endcase
							shift_ff <= (f_data[9:8] == CMD_READ) ? 8'hFF : f_data[7:0];
						end
					end
					CS_START: begin
						case (q_ff)
							2'h0: sda_rel_ff <= 1'b1;
							2'h1: scl_rel_ff <= 1'b1;
							2'h2: sda_rel_ff <= 1'b0;
							default: begin
								scl_rel_ff <= 1'b0;
								state_ff <= CS_BITS;
							end
						endcase
					end
					CS_BITS: begin
						case (q_ff)
							2'h0: begin
								if (bit_ff != BYTE_BITS) begin
									sda_rel_ff <= shift_ff[7];
								end else begin
									// read: give the chosen ack; else release
									sda_rel_ff <= (kind_ff == CMD_READ) ? mack_ff : 1'b1;
								end
							end
							2'h1: scl_rel_ff <= 1'b1;
							2'h2: begin
								if (bit_ff != BYTE_BITS) begin
									shift_ff <= {shift_ff[6:0], sda_s_ff};
								end else begin
									ackbit_ff <= sda_s_ff;
								end
							end
							default: begin
								scl_rel_ff <= 1'b0;
								if (bit_ff == BYTE_BITS) begin
									state_ff <= CS_IDLE;
									rsp_valid_ff <= 1'b1;
									rsp_data_ff <= shift_ff;
									rsp_ack_ff <= ~ackbit_ff;
								end else begin
									bit_ff <= bit_ff + 4'h1;
								end
							end
						endcase
					end
					CS_STOP: begin
						case (q_ff)
							2'h0: sda_rel_ff <= 1'b0;
							2'h1: scl_rel_ff <= 1'b1;
							2'h2: sda_rel_ff <= 1'b1;
							default: state_ff <= CS_IDLE;
						endcase
					end
					default: state_ff <= CS_IDLE;
				endcase
			end
		end
	end

	assign bus.scl_o_h = 1'b0;
	assign bus.scl_oe_h = ~scl_rel_ff;
	assign bus.sda_o_h = 1'b0;
	assign bus.sda_oe_h = ~sda_rel_ff;
	assign rsp_valid_o = rsp_valid_ff;
	assign rsp_data_o = rsp_data_ff;
	assign rsp_ack_o = rsp_ack_ff;
	assign busy_o = (state_ff != CS_IDLE) | f_valid;
endmodule // i2cr_ctrl

/* design/i2cr_fifo.sv */
`timescale 1ns/1ps
module i2cr_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input wire logic clk_i, // system clock
	input wire logic sys_rst_i, // sync reset
	input wire logic in_valid_i, // push request
	output logic in_ready_o, // not full
	input wire logic [WIDTH-1:0] in_data_i, // push word
	output logic out_valid_o, // not empty
	input wire logic out_ready_i, // pop request
	output logic [WIDTH-1:0] out_data_o // head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [AW:0] wr_ff; // write pointer with wrap bit
	logic [AW:0] rd_ff; // read pointer with wrap bit
	logic push;
	logic pop;

	// full when indexes match and wrap bits differ
	assign in_ready_o = (wr_ff[AW-1:0] != rd_ff[AW-1:0]) || (wr_ff[AW] == rd_ff[AW]);
	assign out_valid_o = (wr_ff != rd_ff);
	assign out_data_o = mem[rd_ff[AW-1:0]];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_ready_i & out_valid_o;

	// ----------------------------------------
	// pointers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wr_ff <= '0;
			rd_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= rd_ff + 1'b1;
			end
		end
	end

	// storage needs no reset, empty hides it
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ff[AW-1:0]] <= in_data_i;
		end
	end
endmodule // i2cr_fifo

/* design/i2cr_if.sv */
`timescale 1ns/1ps
// ----------------------------------------
// open-drain wires between controller and target
// ----------------------------------------
interface i2cr_if;
	logic scl_o_h; // controller clock drive value
	logic scl_oe_h; // controller clock enable
	logic sda_o_h; // controller data drive value
	logic sda_oe_h; // controller data enable
	logic sda_o_d; // target data drive value
	logic sda_oe_d; // target data enable
	logic scl; // resolved clock line
	logic sda; // resolved data line

	// pull-ups win unless someone drives low
	assign scl = ~(scl_oe_h & ~scl_o_h);
	assign sda = ~((sda_oe_h & ~sda_o_h) | (sda_oe_d & ~sda_o_d));

	modport dev (input scl, input sda, output sda_o_d, output sda_oe_d);
	modport host (input scl, input sda, output scl_o_h, output scl_oe_h,
		output sda_o_h, output sda_oe_h);
endinterface

/* design/i2cr_pkg.sv */
package i2cr_pkg;
	// ----------------------------------------
	// clocking and link timing
	// ----------------------------------------
	localparam int CLK_HZ = 10_000_000; // system clock rate
	localparam int SCL_MAX_HZ = 1_000_000; // fastest controller rate before high speed
	// quarter bit time in cycles, least time so rounded up
	localparam int QTR_CYC = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
	localparam logic [1:0] QTR_LAST = 2'(QTR_CYC - 1); // divider terminal count

	// ----------------------------------------
	// addressing
	// ----------------------------------------
	localparam logic [6:0] TGT_ADDR_0 = 7'h40; // option 0
	localparam logic [6:0] TGT_ADDR_1 = 7'h44; // option 1
	localparam logic [6:0] TGT_ADDR_2 = 7'h48; // option 2
	localparam logic [6:0] TGT_ADDR_3 = 7'h52; // option 3
	localparam logic [4:0] HS_CODE_TOP = 5'h01; // upper five bits of the master code
	localparam logic [3:0] BYTE_BITS = 4'h8; // data bits before the ack slot
	localparam logic [7:0] REG_RST = 8'h00; // register file reset value
	localparam logic [7:0] PTR_RST = 8'h00; // pointer reset value

	// ----------------------------------------
	// controller command stream
	// ----------------------------------------
	localparam int CMD_W = 10; // kind plus byte
	localparam int FIFO_DEPTH = 16; // command buffer words

	typedef enum logic [1:0] {
		CMD_START = 2'h0, // (repeated) start then send data byte
		CMD_WRITE = 2'h1, // send data byte
		CMD_READ = 2'h2, // receive byte, data[0] is the ack bit to drive
		CMD_STOP = 2'h3 // stop condition
	} i2cr_cmd_t;

	typedef enum logic [2:0] {
		TS_IDLE = 3'h0,
		TS_ADDR = 3'h1,
		TS_PTR = 3'h3,
		TS_WDATA = 3'h2,
		TS_READ = 3'h6,
		TS_SKIP = 3'h7
	} i2cr_tstate_t;

	typedef enum logic [1:0] {
		CS_IDLE = 2'h0,
		CS_START = 2'h1,
		CS_BITS = 2'h3,
		CS_STOP = 2'h2
	} i2cr_cstate_t;

	// strap option to bus address
	function automatic logic [6:0] tgt_addr(input logic [1:0] sel);
		case (sel)
			2'h0: tgt_addr = TGT_ADDR_0;
			2'h1: tgt_addr = TGT_ADDR_1;
			2'h2: tgt_addr = TGT_ADDR_2;
			default: tgt_addr = TGT_ADDR_3;
		endcase
	endfunction
endpackage

/* design/i2cr_target.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - no device identification query support
// - accept standard, fast, fast-plus, high-speed traffic
// - low-speed filters at power-up and stop
// - controller writes address, pointer, then data
// - acknowledge own address and pointer byte
// - single write data may be acked
// - commit written byte on next sda rise, or when the next data byte ends first
// - burst write acks and fills next registers
// - controller ends burst write freely
// - stop restores filters, repeated start keeps
// - read needs pointer write, repeated start
// - send selected register msb first
// - controller nacks last read byte
// - controller ack means send next register
// - stop keeps the register pointer
// - controller sends master code for high speed
// - nack master code, then high-speed filters
// - high speed lasts until the stop
// - acknowledge every pointer value
// - answer only the strapped address
// - never drive the clock line
// - never acknowledge the general call
module i2cr_target import i2cr_pkg::*; (
	input wire logic clk_i, // system clock
	input wire logic sys_rst_i, // sync reset, active high
	i2cr_if.dev bus, // two-wire link
	input wire logic [1:0] addr_sel_i, // address option strap
	input wire logic [7:0] rd_ptr_i, // local read index
	output logic [7:0] rd_data_o, // local read data, one cycle late
	output logic wr_stb_o, // pulse when a byte is committed
	output logic [7:0] wr_ptr_o, // committed register index
	output logic [7:0] wr_data_o, // committed value
	output logic hs_filter_o // high-speed filter select
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	i2cr_tstate_t state_ff; // protocol state
	logic scl_m_ff, scl_s_ff, scl_d_ff; // clock synchroniser and delay
	logic sda_m_ff, sda_s_ff, sda_d_ff; // data synchroniser and delay
	logic strap_ok_ff; // strap captured
	logic [6:0] my_addr_ff; // own address
	logic [3:0] cnt_ff; // bits seen in this byte
	logic ack_ff; // inside the ack slot
	logic [7:0] shift_ff; // receive shifter
	logic [7:0] tx_ff; // transmit shifter
	logic sda_low_ff; // drive data low
	logic rw_ff; // read direction seen
	logic mack_ff; // controller ack sample
	logic [7:0] ptr_ff; // register pointer
	logic pend_ff; // byte waiting for commit
	logic [7:0] pend_ptr_ff; // its index
	logic [7:0] pend_data_ff; // its value
	logic hs_ff; // high-speed filters chosen
	logic [7:0] regs [256]; // register file
	logic wr_stb_ff;
	logic [7:0] wr_ptr_ff;
	logic [7:0] wr_data_ff;
	logic [7:0] rd_data_ff;
	logic scl_rise, scl_fall, sda_rise, start_c, stop_c;
	logic in_rx, byte_done, tx_end, ack_end, addr_hit, commit_now;
	logic [7:0] rd_byte;

	// ----------------------------------------
	// line synchronisers
	// ----------------------------------------
	// idle level is high, so reset to high avoids a false start
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			scl_m_ff <= 1'b1;
			scl_s_ff <= 1'b1;
			scl_d_ff <= 1'b1;
			sda_m_ff <= 1'b1;
			sda_s_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_m_ff <= bus.scl;
			scl_s_ff <= scl_m_ff;
			scl_d_ff <= scl_s_ff;
			sda_m_ff <= bus.sda;
			sda_s_ff <= sda_m_ff;
			sda_d_ff <= sda_s_ff;
		end
	end

	// edges and bus conditions, all from the second stage onward
	// sampling at 10 MHz covers every lower range; high speed needs a faster clock
	assign scl_rise = scl_s_ff & ~scl_d_ff;
	assign scl_fall = ~scl_s_ff & scl_d_ff;
	assign sda_rise = sda_s_ff & ~sda_d_ff;
	assign start_c = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
	assign stop_c = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;

	// byte events
	assign in_rx = (state_ff == TS_ADDR) || (state_ff == TS_PTR) || (state_ff == TS_WDATA);
	assign byte_done = scl_fall & ~ack_ff & (cnt_ff == BYTE_BITS) & in_rx;
	assign tx_end = scl_fall & ~ack_ff & (cnt_ff == BYTE_BITS) & (state_ff == TS_READ);
	assign ack_end = scl_fall & ack_ff;
	// only the strapped address matches; general call and id query fall out
	assign addr_hit = (shift_ff[7:1] == my_addr_ff);
	// next byte after a controller ack comes from the following register
	assign rd_byte = (state_ff == TS_READ) ? regs[ptr_ff + 8'h01] : regs[ptr_ff];

	// ----------------------------------------
	// strap capture
	// ----------------------------------------
	// the strap is taken once, on the first edge after reset release
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			strap_ok_ff <= 1'b0;
			my_addr_ff <= TGT_ADDR_0;
		end else if (!strap_ok_ff) begin
			strap_ok_ff <= 1'b1;
			my_addr_ff <= tgt_addr(addr_sel_i);
		end
	end

	// ----------------------------------------
	// bit engine and protocol state
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_ff <= TS_IDLE;
			cnt_ff <= 4'h0;
			ack_ff <= 1'b0;
			shift_ff <= 8'h00;
			tx_ff <= 8'h00;
			sda_low_ff <= 1'b0;
			rw_ff <= 1'b0;
			mack_ff <= 1'b1;
		end else if (start_c) begin
			// start or repeated start always reopens address phase
			state_ff <= TS_ADDR;
			cnt_ff <= 4'h0;
			ack_ff <= 1'b0;
			sda_low_ff <= 1'b0;
		end else if (stop_c) begin
			state_ff <= TS_IDLE;
			cnt_ff <= 4'h0;
			ack_ff <= 1'b0;
			sda_low_ff <= 1'b0;
		end else begin
			case (state_ff)
				TS_ADDR, TS_PTR, TS_WDATA: begin
					if (scl_rise && !ack_ff && cnt_ff != BYTE_BITS) begin
						shift_ff <= {shift_ff[6:0], sda_s_ff};
						cnt_ff <= cnt_ff + 4'h1;
					end
					if (byte_done) begin
						ack_ff <= 1'b1;
						if (state_ff == TS_ADDR) begin
							// a master code never matches, so it is nacked
							sda_low_ff <= addr_hit;
							rw_ff <= shift_ff[0];
						end else begin
							// every pointer and every data byte is acked
							sda_low_ff <= 1'b1;
						end
					end
					if (ack_end) begin
						ack_ff <= 1'b0;
						cnt_ff <= 4'h0;
						sda_low_ff <= 1'b0;
						if (state_ff == TS_ADDR) begin
							if (!sda_low_ff) begin
								state_ff <= TS_SKIP;
							end else if (rw_ff) begin
								// first bit goes out as the ack slot ends
								state_ff <= TS_READ;
								tx_ff <= {rd_byte[6:0], 1'b0};
								sda_low_ff <= ~rd_byte[7];
							end else begin
								state_ff <= TS_PTR;
							end
						end else begin
							state_ff <= TS_WDATA;
						end
					end
				end
				TS_READ: begin
					if (scl_rise) begin
						if (ack_ff) begin
							mack_ff <= sda_s_ff;
						end else begin
							cnt_ff <= cnt_ff + 4'h1;
						end
					end
					if (tx_end) begin
						// let go so the controller can answer
						ack_ff <= 1'b1;
						sda_low_ff <= 1'b0;
					end else if (scl_fall && !ack_ff) begin
						sda_low_ff <= ~tx_ff[7];
						tx_ff <= {tx_ff[6:0], 1'b0};
					end
					if (ack_end) begin
						ack_ff <= 1'b0;
						cnt_ff <= 4'h0;
						if (!mack_ff) begin
							tx_ff <= {rd_byte[6:0], 1'b0};
							sda_low_ff <= ~rd_byte[7];
						end else begin
							// nack: stay off the line until stop or start
							state_ff <= TS_SKIP;
							sda_low_ff <= 1'b0;
						end
					end
				end
				TS_IDLE, TS_SKIP: begin
					sda_low_ff <= 1'b0;
				end
				default: begin
					state_ff <= TS_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// register pointer
	// ----------------------------------------
	// stop and start leave the pointer alone so a read can repeat
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ptr_ff <= PTR_RST;
		end else if (start_c || stop_c) begin
			ptr_ff <= ptr_ff;
		end else if (byte_done && state_ff == TS_PTR) begin
			ptr_ff <= shift_ff;
		end else if (byte_done && state_ff == TS_WDATA) begin
			ptr_ff <= ptr_ff + 8'h01;
		end else if (ack_end && state_ff == TS_READ && !mack_ff) begin
			ptr_ff <= ptr_ff + 8'h01;
		end
	end

	// ----------------------------------------
	// deferred commit
	// ----------------------------------------
	// a byte lands on the next sda rise; a burst of zero bytes may give
	// no rise, so a newer byte forces the older one in first
	assign commit_now = pend_ff & (sda_rise | (byte_done & (state_ff == TS_WDATA)));

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pend_ff <= 1'b0;
			pend_ptr_ff <= 8'h00;
			pend_data_ff <= 8'h00;
		end else if (byte_done && state_ff == TS_WDATA) begin
			pend_ff <= 1'b1;
			pend_ptr_ff <= ptr_ff;
			pend_data_ff <= shift_ff;
		end else if (commit_now) begin
			pend_ff <= 1'b0;
		end
	end

	// register file with a local read port
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 256; i++) begin
				regs[i] <= REG_RST;
			end
		end else if (commit_now) begin
			regs[pend_ptr_ff] <= pend_data_ff;
		end
	end

	// commit notice and local read
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wr_stb_ff <= 1'b0;
			wr_ptr_ff <= 8'h00;
			wr_data_ff <= 8'h00;
			rd_data_ff <= 8'h00;
		end else begin
			wr_stb_ff <= commit_now;
			if (commit_now) begin
				wr_ptr_ff <= pend_ptr_ff;
				wr_data_ff <= pend_data_ff;
			end
			rd_data_ff <= regs[rd_ptr_i];
		end
	end

	// ----------------------------------------
	// input filter select
	// ----------------------------------------
	// stop wins; repeated start leaves the choice as it is
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			hs_ff <= 1'b0;
		end else if (stop_c) begin
			hs_ff <= 1'b0;
		end else if (ack_end && state_ff == TS_ADDR && shift_ff[7:3] == HS_CODE_TOP) begin
			hs_ff <= 1'b1;
		end
	end

	// the clock line has no driver here at all
	assign bus.sda_o_d = 1'b0;
	assign bus.sda_oe_d = sda_low_ff;
	assign rd_data_o = rd_data_ff;
	assign wr_stb_o = wr_stb_ff;
	assign wr_ptr_o = wr_ptr_ff;
	assign wr_data_o = wr_data_ff;
	assign hs_filter_o = hs_ff;
endmodule // i2cr_target

/* tb/i2cr_asserts.sv */
`timescale 1ns/1ps
module i2cr_asserts import i2cr_pkg::*; (
	input wire logic clk_i, // system clock
	input wire logic sys_rst_i, // sync reset
	input wire logic [6:0] ad_i, // strapped target address, may change under reset
	input wire logic scl, // resolved clock line
	input wire logic sda, // resolved data line
	input wire logic sda_o_d, // target drive value
	input wire logic sda_oe_d // target drive enable
);
	// ----------------------------------------
	// frame tracking at clock rate
	// ----------------------------------------
	logic scl_ff, sda_ff; // last line samples
	logic [3:0] bit_ff; // bit index inside the byte
	logic [1:0] byte_ff; // byte index, stops at 2
	logic [7:0] sh_ff, adr_ff; // shifted bits, first byte
	wire rise = scl & ~scl_ff; // clock rise seen
	wire ackr = rise && bit_ff == 4'h8; // ack slot sample point
	wire strt = scl & scl_ff & sda_ff & ~sda; // start or repeated start
	// line history
	always_ff @(posedge clk_i) begin
		scl_ff <= scl;
		sda_ff <= sda;
	end
	// bit and byte counts restart at every start
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || strt) begin
			bit_ff <= 4'h0;
			byte_ff <= 2'h0;
		end else if (ackr) begin
			bit_ff <= 4'h0;
			byte_ff <= (byte_ff == 2'h2) ? 2'h2 : byte_ff + 2'h1;
			adr_ff <= (byte_ff == 2'h0) ? sh_ff : adr_ff;
		end else if (rise) begin
			bit_ff <= bit_ff + 4'h1;
			sh_ff <= {sh_ff[6:0], sda};
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	AST_OWN_ACK: assert property (ackr && byte_ff == 2'h0 && sh_ff[7:1] == ad_i |-> !sda)
		else $error("own address not acked");
	AST_OTHER_NACK: assert property (ackr && byte_ff == 2'h0 && sh_ff[7:1] != ad_i |-> sda)
		else $error("foreign address acked");
	AST_GCALL_NACK: assert property (ackr && byte_ff == 2'h0 && sh_ff == 8'h00 |-> sda)
		else $error("general call acked");
	AST_MCODE: assert property (ackr && byte_ff == 2'h0 && sh_ff[7:3] == HS_CODE_TOP |-> sda)
		else $error("master code acked");
	AST_PTR_ACK: assert property (ackr && byte_ff == 2'h1 && adr_ff == {ad_i, 1'b0} |-> !sda)
		else $error("pointer not acked");
	AST_BURST_ACK: assert property (ackr && byte_ff == 2'h2 && adr_ff == {ad_i, 1'b0} |-> !sda)
		else $error("burst byte not acked");
	AST_RD_FREE: assert property (ackr && byte_ff != 2'h0 && adr_ff == {ad_i, 1'b1} |-> !sda_oe_d)
		else $error("target drives the ack of a read byte");
	AST_LOW_ONLY: assert property (sda_oe_d |-> !sda_o_d ##1 !scl_ff || !$changed(sda_oe_d))
		else $error("target drives high or moves data with clock high");
	cover property (ackr && byte_ff == 2'h2);
	cover property (ackr && adr_ff == {ad_i, 1'b1});
	cover property (ackr && sh_ff[7:3] == HS_CODE_TOP);
endmodule // i2cr_asserts

/* tb/tb.sv */
`timescale 1ns/1ps
module tb import i2cr_pkg::*;;
	logic clk_i, sys_rst_i, req_valid, req_ready, rsp_valid, rsp_ack, busy, wr_stb, hs;
	logic [1:0] req_kind, addr_sel;
	logic [6:0] own; // address the checker expects
	logic [7:0] req_data, rsp_data, rd_ptr, rd_data, wr_ptr, wr_data, base, p;
	logic [8:0] exp_rsp[$]; // {ack, byte} per byte command
	logic [15:0] exp_wr[$]; // {index, value} per commit
	logic [7:0] mem [256]; // expected register image
	logic [31:0] rng, tmp; // xorshift state
	int bad_count, checks_done, cyc, stall;
	i2cr_if u_i2cr_if();
	i2cr_ctrl u_i2cr_ctrl (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(u_i2cr_if.host),
		.req_valid_i(req_valid), .req_ready_o(req_ready), .req_kind_i(req_kind),
		.req_data_i(req_data), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
		.rsp_ack_o(rsp_ack), .busy_o(busy));
	i2cr_target u_i2cr_target (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(u_i2cr_if.dev),
		.addr_sel_i(addr_sel), .rd_ptr_i(rd_ptr), .rd_data_o(rd_data), .wr_stb_o(wr_stb),
		.wr_ptr_o(wr_ptr), .wr_data_o(wr_data), .hs_filter_o(hs));
	i2cr_asserts u_i2cr_asserts (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ad_i(own),
		.scl(u_i2cr_if.scl), .sda(u_i2cr_if.sda), .sda_o_d(u_i2cr_if.sda_o_d),
		.sda_oe_d(u_i2cr_if.sda_oe_d));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task automatic note(input bit ok, input string what);
		checks_done++;
		if (!ok) begin
			bad_count++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask
	task automatic cmp_rsp(input logic [8:0] g, input logic [8:0] e);
		note(g === e, "byte result");
	endtask
	task automatic cmp_wr(input logic [15:0] g, input logic [15:0] e);
		note(g === e, "register commit");
	endtask
	task automatic cmp_lvl(input logic [7:0] g, input logic [7:0] e);
		note(g === e, "output level");
	endtask
	// offer one command, holding it until the buffer takes it
	task automatic cmd(input i2cr_cmd_t k, input logic [7:0] d, input logic [8:0] e);
		#2;
		req_valid = 1'b1;
		req_kind = k;
		req_data = d;
		if (k != CMD_STOP) exp_rsp.push_back(e);
		@(posedge clk_i);
		while (req_ready !== 1'b1) begin
			stall++;
			@(posedge clk_i);
		end
	endtask
	// let the controller drain everything
	task automatic idle();
		#2;
		req_valid = 1'b0;
		repeat (3) @(posedge clk_i);
		while (busy !== 1'b0) @(posedge clk_i);
		repeat (8) @(posedge clk_i);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// results are matched against the oldest note; the cycle ceiling cuts a hang
	always @(posedge clk_i) begin
		cyc++;
		if (rsp_valid === 1'b1) cmp_rsp({rsp_ack, rsp_data}, exp_rsp.pop_front());
		if (wr_stb === 1'b1) cmp_wr({wr_ptr, wr_data}, exp_wr.pop_front());
		if (cyc == 20000) begin
			bad_count++;
			test_done();
		end
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		{sys_rst_i, req_valid, req_kind, req_data, rd_ptr, addr_sel, rng} = {1'b1, 21'h0, 32'h25};
		own = TGT_ADDR_0;
		{bad_count, checks_done, cyc, stall} = '0;
		foreach (mem[i]) mem[i] = REG_RST;
		repeat (3) @(posedge clk_i);
		#2 sys_rst_i = 1'b0;
		repeat (4) @(posedge clk_i);
		cmp_lvl({7'h0, hs}, 8'h00);
		tmp = rnd();
		base = {1'b0, tmp[6:0]};
		cmd(CMD_START, 8'h80, 9'h180);
		cmd(CMD_WRITE, base, {1'b1, base});
		for (int i = 0; i < 16; i++) begin
			tmp = rnd();
			mem[8'(base + i)] = tmp[7:0];
			exp_wr.push_back({8'(base + i), tmp[7:0]});
			cmd(CMD_WRITE, tmp[7:0], {1'b1, tmp[7:0]});
		end
		cmd(CMD_STOP, 8'h00, 9'h000);
		idle();
		cmp_lvl({7'h0, stall != 0}, 8'h01);
		#2 rd_ptr = base + 8'h05;
		repeat (2) @(posedge clk_i);
		cmp_lvl(rd_data, mem[rd_ptr]);
		$display("burst write done");
		p = base + 8'h02;
		cmd(CMD_START, 8'h80, 9'h180);
		cmd(CMD_WRITE, p, {1'b1, p});
		cmd(CMD_START, 8'h81, 9'h181);
		for (int i = 0; i < 4; i++) cmd(CMD_READ, {7'h0, i == 3}, {i != 3, mem[8'(p + i)]});
		cmd(CMD_STOP, 8'h00, 9'h000);
		cmd(CMD_START, 8'h81, 9'h181);
		cmd(CMD_READ, 8'h01, {1'b0, mem[p + 8'h03]});
		cmd(CMD_STOP, 8'h00, 9'h000);
		idle();
		$display("burst and repeated read done");
		for (int i = 0; i < 4; i++) begin
			tmp[7:0] = i == 0 ? 8'h88 : i == 1 ? 8'h00 : i == 2 ? 8'hF8 : 8'h82;
			cmd(CMD_START, tmp[7:0], {1'b0, tmp[7:0]});
			cmd(CMD_STOP, 8'h00, 9'h000);
		end
		idle();
		$display("refused addresses done");
		tmp = rnd();
		cmd(CMD_START, {HS_CODE_TOP, tmp[2:0]}, {1'b0, HS_CODE_TOP, tmp[2:0]});
		cmd(CMD_START, 8'h80, 9'h180);
		cmd(CMD_WRITE, 8'hFE, 9'h1FE);
		mem[8'hFE] = tmp[15:8];
		exp_wr.push_back({8'hFE, tmp[15:8]});
		cmd(CMD_WRITE, tmp[15:8], {1'b1, tmp[15:8]});
		idle();
		cmp_lvl({7'h0, hs}, 8'h01);
		cmd(CMD_START, 8'h81, 9'h181);
		cmd(CMD_READ, 8'h01, {1'b0, mem[8'hFF]});
		cmd(CMD_STOP, 8'h00, 9'h000);
		idle();
		cmp_lvl({7'h0, hs}, 8'h00);
		$display("high speed entry done");
		// leave high speed selected, then reset mid-run with another strap
		cmd(CMD_START, 8'h08, 9'h008);
		idle();
		cmp_lvl({7'h0, hs}, 8'h01);
		#2 sys_rst_i = 1'b1;
		addr_sel = 2'h3;
		own = TGT_ADDR_3;
		foreach (mem[i]) mem[i] = REG_RST;
		repeat (3) @(posedge clk_i);
		#2 sys_rst_i = 1'b0;
		repeat (4) @(posedge clk_i);
		cmp_lvl({7'h0, hs}, 8'h00);
		cmd(CMD_START, 8'h80, 9'h080);
		cmd(CMD_STOP, 8'h00, 9'h000);
		cmd(CMD_START, {TGT_ADDR_3, 1'b1}, {1'b1, TGT_ADDR_3, 1'b1});
		cmd(CMD_READ, 8'h01, {1'b0, mem[PTR_RST]});
		cmd(CMD_STOP, 8'h00, 9'h000);
		idle();
		cmp_lvl(8'(exp_rsp.size() + exp_wr.size()), 8'h00);
		$display("strap and reset done");
		test_done();
	end
endmodule // tb
